// ---- design/simc_params.svh ----
// constants for the system init, mode and memory-map control block
// assumes an 8-bit register file reached over a 32-bit Avalon-MM slave
`ifndef SIMC_PARAMS_SVH
`define SIMC_PARAMS_SVH

// register indices; byte address is four times the index
`define SIMC_IDX_TIMER_MASK_TWO      7'h24
`define SIMC_IDX_BLOCK_PROTECT       7'h35
`define SIMC_IDX_EEPROM_MAP          7'h37
`define SIMC_IDX_OPTIONS_TWO         7'h38
`define SIMC_IDX_OPTIONS             7'h39
`define SIMC_IDX_PRIORITY_FLAGS      7'h3c
`define SIMC_IDX_RAM_REG_MAP         7'h3d
`define SIMC_IDX_CONFIG_LATCHES      7'h3f

// reset values
`define SIMC_RST_TIMER_MASK_TWO      8'h00
`define SIMC_RST_BLOCK_PROTECT       8'hbf
`define SIMC_RST_EEPROM_MAP          8'h00
`define SIMC_RST_OPTIONS_TWO         8'h00
`define SIMC_RST_OPTIONS             8'h10
`define SIMC_RST_PRIORITY_SEL        5'h06
`define SIMC_RST_RAM_REG_MAP         8'h00

// field masks
`define SIMC_MASK_TMSK_LIMITED       8'h03
`define SIMC_MASK_BLOCK_PROTECT_REGISTER_USED         8'hbf
`define SIMC_MASK_OPTIONS_LIMITED    8'h37
`define SIMC_MASK_SYSTEM_OPTIONS_TWO_USED          8'hfc
`define SIMC_BIT_SYSTEM_OPTIONS_TWO_READ_VIS       4
`define SIMC_MASK_SYSTEM_OPTIONS_TWO_READ_VIS      8'h10
`define SIMC_MASK_CONFIG_ONES        8'h60
`define SIMC_BIT_CFG_ROM_PLACE       7
`define SIMC_BIT_CFG_PULLUP_EN       4
`define SIMC_BIT_CFG_SECURITY_DIS    3
`define SIMC_BIT_CFG_WATCHDOG_DIS    2
`define SIMC_BIT_CFG_ROM_EN          1
`define SIMC_BIT_CFG_EEPROM_EN       0

// limited-write window in E cycles after reset release
`define SIMC_WINDOW_CYCLES           7'd64

// vectors and memory map
`define SIMC_VECTOR_NORMAL           16'hfffa
`define SIMC_VECTOR_SPECIAL          16'hbffa
`define SIMC_BOOT_ROM_LO             16'hbe40
`define SIMC_BOOT_ROM_HI             16'hbfff
`define SIMC_REG_BLOCK_SIZE          16'h0080
`define SIMC_RAM_LAST_OFFSET         16'h03ff
`define SIMC_EEPROM_LO_OFFSET        12'hd80

`endif

// ---- design/simc_pkg.sv ----
// types for the system init, mode and memory-map control block
// assumes simc_params.svh supplies the numeric constants
package simc_pkg;

    // latched operating-mode flags
    typedef struct packed {
        logic boot_rom_enable;
        logic special_mode_flag;
        logic expanded_mode_flag;
    } simc_flags_t;

    // settings handed to the rest of the chip
    typedef struct packed {
        logic       rom_placement_bit;
        logic       rom_enable_bit;
        logic       eeprom_enable_bit;
        logic       watchdog_enable;
        logic       pullup_register_enable;
        logic       security_disable_bit;
        logic       internal_read_visibility_control;
        logic [4:0] priority_select;
    } simc_ctrl_t;

    // memory map selects for the current cpu address; reg_block and ram exclude the rest
    typedef struct packed {
        logic reg_block;
        logic ram;
        logic boot_rom;
        logic eeprom;
        logic rom;
    } simc_map_sel_t;

endpackage

// ---- design/simc_top.sv ----
// system init, mode latch, limited-write protection and memory-map decode
// assumes sys_clk_i is the E clock; straps come from board pins
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "simc_params.svh"

module simc_top
    import simc_pkg::*;
(
    // clock and reset
    input  wire  logic          sys_clk_i,
    input  wire  logic          rst_b_i,
    // avalon-mm slave
    input  wire  logic [8:0]    avs_address_i,
    input  wire  logic          avs_read_i,
    input  wire  logic          avs_write_i,
    input  wire  logic [31:0]   avs_writedata_i,
    input  wire  logic [3:0]    avs_byteenable_i,
    output logic       [31:0]   avs_readdata_o,
    output logic                avs_waitrequest_o,
    // mode strap pins
    input  wire  logic          mode_strap_a_i,
    output logic                mode_strap_a_o,
    output logic                mode_strap_a_oe_o,
    input  wire  logic          mode_strap_b_i,
    // core and eeprom side
    input  wire  logic          instr_first_cycle_i,
    input  wire  logic [7:0]    config_cells_i,
    input  wire  logic [15:0]   cpu_addr_i,
    // outputs to the chip
    output simc_flags_t         mode_flags_o,
    output simc_ctrl_t          ctrl_o,
    output simc_map_sel_t       map_sel_o,
    output logic       [15:0]   reset_vector_o,
    output logic       [7:0]    timer_mask_two_o,
    output logic       [7:0]    block_protect_o,
    output logic       [7:0]    options_o,
    output logic       [7:0]    options_two_o,
    output logic       [7:0]    eeprom_map_o
);

    function automatic simc_flags_t mode_decode(input logic [1:0] ba);
        simc_flags_t f;
        f.boot_rom_enable    = ~ba[1] & ~ba[0];
        f.special_mode_flag  = ~ba[1];
        f.expanded_mode_flag = ba[0];
        return f;
    endfunction

    logic [1:0]  strap_meta_q;
    logic [1:0]  strap_sync_q;
    simc_flags_t flags_q;
    logic [4:0]  prio_sel_q;
    logic        vec_special_q;
    logic        test_mode_q;
    logic        run_q;
    logic [6:0]  win_cnt_q;
    logic        window_open;
    logic        ack_q;
    logic [7:0]  rd_q;
    logic        wr_fire;
    logic [7:0]  wdata;
    logic [6:0]  widx;
    logic [7:0]  tmsk_q;
    logic        tmsk_once_q;
    logic [7:0]  block_protect_register_q;
    logic        block_protect_register_once_q;
    logic [7:0]  opt_q;
    logic        opt_once_q;
    logic [7:0]  system_options_two_q;
    logic        system_options_two_once_q;
    logic [7:0]  eemap_q;
    logic        eemap_once_q;
    logic [7:0]  rammap_q;
    logic        rammap_once_q;
    logic [7:0]  cfg_q;
    logic [7:0]  cfg_rst;
    logic        special;
    logic [15:0] reg_base;
    logic [15:0] ram_base;
    logic        in_reg;
    logic        in_ram;

    assign special = flags_q.special_mode_flag;

    // strap synchroniser; keeps sampling through reset
    always_ff @(posedge sys_clk_i) begin
        strap_meta_q <= {mode_strap_b_i, mode_strap_a_i};
        strap_sync_q <= strap_meta_q;
    end

    // mode flags latched while reset is low, then writable only in special mode
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            flags_q       <= mode_decode(strap_sync_q);
            vec_special_q <= ~strap_sync_q[1];
            test_mode_q   <= ~strap_sync_q[1] & strap_sync_q[0];
        end else if (wr_fire && widx == `SIMC_IDX_PRIORITY_FLAGS && special) begin
            flags_q.boot_rom_enable    <= wdata[7];
            flags_q.special_mode_flag  <= wdata[6];
            flags_q.expanded_mode_flag <= wdata[5];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i)
            prio_sel_q <= `SIMC_RST_PRIORITY_SEL;
        else if (wr_fire && widx == `SIMC_IDX_PRIORITY_FLAGS)
            prio_sel_q <= wdata[4:0];
    end

    // run flag and limited-write window counter
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            run_q     <= 1'b0;
            win_cnt_q <= 7'h00;
        end else begin
            run_q <= 1'b1;
            if (window_open)
                win_cnt_q <= win_cnt_q + 7'h01;
        end
    end
    assign window_open = win_cnt_q < `SIMC_WINDOW_CYCLES;

    // strap A doubles as open-drain fetch indicator outside reset
    assign mode_strap_a_o    = 1'b0;
    assign mode_strap_a_oe_o = run_q & rst_b_i & instr_first_cycle_i;

    // avalon slave: one wait cycle, then answer
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i)
            ack_q <= 1'b0;
        else
            ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
    end
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
    assign wr_fire = avs_write_i & ack_q & avs_byteenable_i[0];
    assign wdata   = avs_writedata_i[7:0];
    assign widx    = avs_address_i[8:2];

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            rd_q <= 8'h00;
        end else if (avs_read_i && !ack_q) begin
            unique case (widx)
                `SIMC_IDX_TIMER_MASK_TWO: rd_q <= tmsk_q;
                `SIMC_IDX_BLOCK_PROTECT:  rd_q <= block_protect_register_q;
                `SIMC_IDX_EEPROM_MAP:     rd_q <= eemap_q;
                `SIMC_IDX_OPTIONS_TWO:    rd_q <= system_options_two_q;
                `SIMC_IDX_OPTIONS:        rd_q <= opt_q;
                `SIMC_IDX_PRIORITY_FLAGS: rd_q <= {flags_q, prio_sel_q};
                `SIMC_IDX_RAM_REG_MAP:    rd_q <= rammap_q;
                `SIMC_IDX_CONFIG_LATCHES: rd_q <= cfg_q;
                default:                  rd_q <= 8'h00;
            endcase
        end
    end
    assign avs_readdata_o = {24'h000000, rd_q};

    // timer mask two
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            tmsk_q      <= `SIMC_RST_TIMER_MASK_TWO;
            tmsk_once_q <= 1'b0;
        end else if (wr_fire && widx == `SIMC_IDX_TIMER_MASK_TWO) begin
            if (special || (window_open && !tmsk_once_q)) begin
                tmsk_q      <= wdata;
                tmsk_once_q <= 1'b1;
            end else begin
                tmsk_q <= (wdata & ~`SIMC_MASK_TMSK_LIMITED) |
                          (tmsk_q & `SIMC_MASK_TMSK_LIMITED);
            end
        end
    end

    // block protect: setting always allowed, clearing guarded
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            block_protect_register_q      <= `SIMC_RST_BLOCK_PROTECT;
            block_protect_register_once_q <= 1'b0;
        end else if (wr_fire && widx == `SIMC_IDX_BLOCK_PROTECT) begin
            if (special || (window_open && !block_protect_register_once_q)) begin
                block_protect_register_q      <= wdata & `SIMC_MASK_BLOCK_PROTECT_REGISTER_USED;
                block_protect_register_once_q <= ~special;
            end else begin
                block_protect_register_q <= block_protect_register_q | (wdata & `SIMC_MASK_BLOCK_PROTECT_REGISTER_USED);
            end
        end
    end

    // system options
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            opt_q      <= `SIMC_RST_OPTIONS;
            opt_once_q <= 1'b0;
        end else if (wr_fire && widx == `SIMC_IDX_OPTIONS) begin
            if (special || (window_open && !opt_once_q)) begin
                opt_q      <= wdata;
                opt_once_q <= 1'b1;
            end else begin
                opt_q <= (wdata & ~`SIMC_MASK_OPTIONS_LIMITED) |
                         (opt_q & `SIMC_MASK_OPTIONS_LIMITED);
            end
        end
    end

    // system options two; read visibility resets to one in test mode
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            system_options_two_q      <= `SIMC_RST_OPTIONS_TWO;
            system_options_two_once_q <= 1'b0;
        end else if (!run_q) begin
            system_options_two_q[`SIMC_BIT_SYSTEM_OPTIONS_TWO_READ_VIS] <= test_mode_q;
        end else if (wr_fire && widx == `SIMC_IDX_OPTIONS_TWO) begin
            if (!system_options_two_once_q || test_mode_q) begin
                system_options_two_q      <= wdata & `SIMC_MASK_SYSTEM_OPTIONS_TWO_USED;
                system_options_two_once_q <= 1'b1;
            end else begin
                system_options_two_q <= (wdata & `SIMC_MASK_SYSTEM_OPTIONS_TWO_USED & ~`SIMC_MASK_SYSTEM_OPTIONS_TWO_READ_VIS) |
                          (system_options_two_q & `SIMC_MASK_SYSTEM_OPTIONS_TWO_READ_VIS);
            end
        end
    end

    // eeprom map: upper nibble once in normal modes
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            eemap_q      <= `SIMC_RST_EEPROM_MAP;
            eemap_once_q <= 1'b0;
        end else if (wr_fire && widx == `SIMC_IDX_EEPROM_MAP) begin
            eemap_q[3:0] <= wdata[3:0];
            if (special || !eemap_once_q) begin
                eemap_q[7:4] <= wdata[7:4];
                eemap_once_q <= ~special;
            end
        end
    end

    // ram and register map: single write inside the window
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            rammap_q      <= `SIMC_RST_RAM_REG_MAP;
            rammap_once_q <= 1'b0;
        end else if (wr_fire && widx == `SIMC_IDX_RAM_REG_MAP &&
                     window_open && !rammap_once_q) begin
            rammap_q      <= wdata;
            rammap_once_q <= 1'b1;
        end
    end

    // config latches loaded from eeprom cells with mode overrides
    always_comb begin
        cfg_rst = config_cells_i | `SIMC_MASK_CONFIG_ONES;
        if (!strap_sync_q[1] && strap_sync_q[0])
            cfg_rst[`SIMC_BIT_CFG_ROM_EN] = 1'b0;
        if (strap_sync_q[1] && !strap_sync_q[0]) begin
            cfg_rst[`SIMC_BIT_CFG_ROM_EN]    = 1'b1;
            cfg_rst[`SIMC_BIT_CFG_ROM_PLACE] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i)
            cfg_q <= cfg_rst;
        else if (wr_fire && widx == `SIMC_IDX_CONFIG_LATCHES && special)
            cfg_q <= wdata | `SIMC_MASK_CONFIG_ONES;
    end

    // memory map decode, registered
    always_comb begin
        reg_base = {rammap_q[3:0], 12'h000};
        ram_base = {rammap_q[7:4], 12'h000};
        if (rammap_q[7:4] == rammap_q[3:0])
            ram_base = ram_base + `SIMC_REG_BLOCK_SIZE;
        in_reg = cpu_addr_i >= reg_base &&
                 cpu_addr_i - reg_base < `SIMC_REG_BLOCK_SIZE;
        in_ram = cpu_addr_i >= ram_base &&
                 cpu_addr_i - ram_base <= `SIMC_RAM_LAST_OFFSET;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            map_sel_o <= '0;
        end else begin
            map_sel_o.reg_block <= in_reg;
            map_sel_o.ram       <= in_ram & ~in_reg;
            map_sel_o.boot_rom  <= flags_q.boot_rom_enable & ~in_reg & ~in_ram &
                                   cpu_addr_i >= `SIMC_BOOT_ROM_LO &&
                                   cpu_addr_i <= `SIMC_BOOT_ROM_HI;
            map_sel_o.eeprom    <= cfg_q[`SIMC_BIT_CFG_EEPROM_EN] & ~in_reg & ~in_ram &
                                   cpu_addr_i[15:12] == eemap_q[7:4] &&
                                   cpu_addr_i[11:0] >= `SIMC_EEPROM_LO_OFFSET;
            map_sel_o.rom       <= cfg_q[`SIMC_BIT_CFG_ROM_EN] & ~in_reg & ~in_ram &
                                   (cpu_addr_i[15] == cfg_q[`SIMC_BIT_CFG_ROM_PLACE]);
        end
    end

    // registered outputs
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            reset_vector_o <= `SIMC_VECTOR_NORMAL;
            ctrl_o         <= '0;
        end else begin
            reset_vector_o <= vec_special_q ? `SIMC_VECTOR_SPECIAL
                                            : `SIMC_VECTOR_NORMAL;
            ctrl_o.rom_placement_bit      <= cfg_q[`SIMC_BIT_CFG_ROM_PLACE];
            ctrl_o.rom_enable_bit         <= cfg_q[`SIMC_BIT_CFG_ROM_EN];
            ctrl_o.eeprom_enable_bit      <= cfg_q[`SIMC_BIT_CFG_EEPROM_EN];
            ctrl_o.watchdog_enable        <= ~cfg_q[`SIMC_BIT_CFG_WATCHDOG_DIS];
            ctrl_o.pullup_register_enable <= cfg_q[`SIMC_BIT_CFG_PULLUP_EN];
            ctrl_o.security_disable_bit   <= cfg_q[`SIMC_BIT_CFG_SECURITY_DIS];
            ctrl_o.internal_read_visibility_control <= system_options_two_q[`SIMC_BIT_SYSTEM_OPTIONS_TWO_READ_VIS];
            ctrl_o.priority_select        <= prio_sel_q;
        end
    end

    assign mode_flags_o     = flags_q;
    assign timer_mask_two_o = tmsk_q;
    assign block_protect_o  = block_protect_register_q;
    assign options_o        = opt_q;
    assign options_two_o    = system_options_two_q;
    assign eeprom_map_o     = eemap_q;

    a_strap_mode_latch: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        $rose(rst_b_i) |-> flags_q == mode_decode($past(strap_sync_q)))
        else $error("mode flags differ from strap decode");

    a_window_length: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        $rose(rst_b_i) |-> ##63 window_open ##1 !window_open)
        else $error("write window not 64 cycles");

    a_fetch_drive: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        mode_strap_a_oe_o |-> instr_first_cycle_i && !mode_strap_a_o && run_q)
        else $error("fetch indicator driven wrongly");

    a_vector_select: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        run_q |-> reset_vector_o == (vec_special_q ? `SIMC_VECTOR_SPECIAL
                                                   : `SIMC_VECTOR_NORMAL))
        else $error("reset vector select wrong");

    a_special_sticky: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !special |=> !special)
        else $error("special flag set again");

    a_tmsk_locked: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        wr_fire && widx == `SIMC_IDX_TIMER_MASK_TWO && !special && !window_open
        |=> tmsk_q[1:0] == $past(tmsk_q[1:0]))
        else $error("timer mask low bits changed after window");

    a_block_protect_register_set_only: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        wr_fire && widx == `SIMC_IDX_BLOCK_PROTECT && !special && !window_open
        |=> block_protect_register_q == ($past(block_protect_register_q) | ($past(wdata) & `SIMC_MASK_BLOCK_PROTECT_REGISTER_USED)))
        else $error("block protect cleared outside window");

    a_rammap_frozen: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        !window_open |=> $stable(rammap_q))
        else $error("ram map changed after window");

    a_config_ones: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        run_q |-> cfg_q[6:5] == 2'b11)
        else $error("config unused bits not one");

    a_wait_one: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("waitrequest held over one cycle");

endmodule
`default_nettype wire

// ---- test/simc_pin_model.sv ----
// board side of the mode strap pins and the fetch indicator line
// assumes strap levels come from the bench and oe from the device
`timescale 1ns/1ps
`default_nettype none
module simc_pin_model (
    // board levels and device drive
    input  wire logic strap_a_i,
    input  wire logic strap_b_i,
    input  wire logic rst_b_i,
    input  wire logic fetch_oe_i,
    // pin levels seen by the device
    output logic      pin_a_o,
    output logic      pin_b_o
);
    // open-drain: device pulls low while fetch_oe_i is set outside reset, else strap or pull-up level
    assign pin_a_o = (rst_b_i && fetch_oe_i) ? 1'b0 : strap_a_i;
    assign pin_b_o = strap_b_i;
endmodule
`default_nettype wire

// ---- test/simc_top_tb.sv ----
// self-checking bench for simc_top against an integer register model
// assumes simc_pin_model stands for the board straps
`timescale 1ns/1ps
`default_nettype none
module simc_top_tb;
    import simc_pkg::*;
    logic          clk = 0, rst_b = 0, rd = 0, wr = 0, sa = 0, sb = 1, ifc = 0;
    logic [8:0]    adr = 0;
    logic [31:0]   wd = 0, q, rdat;
    logic [7:0]    cells = 0;
    logic [15:0]   ca = 0, vec;
    logic          wreq, a_o, a_oe, pa, pb;
    simc_flags_t   flg;
    simc_ctrl_t    ctl;
    simc_map_sel_t ms;
    int            errors = 0, tests_run = 0, cyc = 0, mr[int];
    bit            used[int];
    bit            tm;
    logic [7:0]    tmo, bpo, emo, o2o, opo;
    logic [31:0]   rng = 17;

    initial forever #25 clk = ~clk;

    simc_pin_model u_simc_pin_model (.strap_a_i(sa), .strap_b_i(sb), .rst_b_i(rst_b),
        .fetch_oe_i(a_oe), .pin_a_o(pa), .pin_b_o(pb));
    simc_top u_simc_top (.sys_clk_i(clk), .rst_b_i(rst_b), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'h1),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .mode_strap_a_i(pa),
        .mode_strap_a_o(a_o), .mode_strap_a_oe_o(a_oe), .mode_strap_b_i(pb),
        .instr_first_cycle_i(ifc), .config_cells_i(cells), .cpu_addr_i(ca),
        .mode_flags_o(flg), .ctrl_o(ctl), .map_sel_o(ms), .reset_vector_o(vec),
        .timer_mask_two_o(tmo), .block_protect_o(bpo), .options_o(opo), .options_two_o(o2o),
        .eeprom_map_o(emo));

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // next register value; f = first write inside the window
    function automatic int nxt(int i, int o, int d, bit f, bit sm);
        case (i)
            'h24: return (sm || f) ? d : (o & 3) | (d & 'hfc);
            'h35: return (sm || f) ? d & 'hbf : (o | d) & 'hbf;
            'h37: return (sm || !used[i]) ? d : (o & 'hf0) | (d & 'h0f);
            'h38: return (tm || !used[i]) ? d & 'hfc : (o & 'h10) | (d & 'hec);
            'h39: return (sm || f) ? d : (o & 'h37) | (d & 'hc8);
            'h3c: return sm ? d : (o & 'he0) | (d & 'h1f);
            'h3d: return f ? d : o;
            'h3f: return sm ? d | 'h60 : o;
            default: return o;
        endcase
    endfunction

    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic bus(bit w, int i, int d);
        @(posedge clk);
        adr <= 9'(i * 4);
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        q = rdat;
        wr <= 0;
        rd <= 0;
    endtask

    task automatic wchk(int i, int d, bit win);
        mr[i] = nxt(i, mr[i], d, !used[i] && win, mr['h3c][6]);
        used[i] = 1;
        bus(1, i, d);
        bus(0, i, 0);
        chk("register", q, mr[i]);
        case (i)
            'h24: chk("timer mask out", tmo, mr[i]);
            'h35: chk("block protect out", bpo, mr[i]);
            'h37: chk("eeprom map out", emo, mr[i]);
            'h38: chk("options two out", o2o, mr[i]);
            'h39: chk("options out", opo, mr[i]);
            default: ;
        endcase
    endtask

    task automatic mchk(logic [15:0] a, logic [4:0] e);
        @(posedge clk);
        ca <= a;
        @(posedge clk);
        @(negedge clk);
        chk("map", ms, e);
    endtask

    // straps per mode j: 0 single chip, 1 expanded, 2 bootstrap, 3 test
    task automatic rst(int j);
        logic [7:0] c;
        c = 8'(xs());
        if (j == 0) c[0] = 1;
        if (j == 2) c[1] = 0;
        @(posedge clk);
        rst_b <= 0;
        sb <= (j < 2);
        sa <= j[0];
        cells <= c;
        repeat (16) @(posedge clk);
        rst_b <= 1;
        used.delete();
        mr = '{'h24: 0, 'h35: 'hbf, 'h37: 0, 'h39: 'h10, 'h3d: 0};
        mr['h38] = (j == 3) ? 'h10 : 0;
        tm = (j == 3);
        mr['h3c] = {j == 2, j > 1, j[0], 5'h06};
        c = c | 8'h60;
        if (j == 0) c = c | 8'h82;
        if (j == 3) c[1] = 0;
        mr['h3f] = c;
    endtask

    task automatic end_sim();
        if (errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            errors++;
            end_sim();
        end
    end

    initial begin
        for (int j = 0; j < 4; j++) begin
            rst(j);
            if (j == 0) begin
                wchk('h3d, 'h11, 1);
                wchk('h3d, 'h22, 1);
                wchk('h24, 'hff, 1);
                wchk('h24, 'h00, 1);
                wchk('h39, 'h00, 1);
                wchk('h39, 'hff, 1);
                wchk('h35, 'h00, 1);
                wchk('h35, 'hbf, 0);
                wchk('h35, 'h00, 0);
                wchk('h37, 'h5a, 0);
                wchk('h37, 'ha5, 0);
                wchk('h3c, 'hff, 0);
                wchk('h3f, 'h00, 0);
                wchk('h38, 'hff, 0);
                wchk('h38, 'h00, 0);
                bus(0, 'h00, 0);
                chk("unmapped", q, 0);
                mchk(16'h1000, 5'h10);
                mchk(16'h1080, 5'h08);
                mchk(16'h5d80, 5'h02);
                mchk(16'h8000, 5'h01);
            end
            if (j == 1) begin
                repeat (70) @(posedge clk);
                wchk('h3d, 'h33, 0);
                wchk('h24, 'h03, 0);
                wchk('h35, 'h00, 0);
            end
            if (j == 3) begin
                wchk('h38, 'h00, 0);
                wchk('h38, 'hff, 0);
            end
            if (j == 2) begin
                mchk(16'hbe40, 5'h04);
                wchk('h24, 'hff, 0);
                wchk('h24, 'h00, 0);
                wchk('h3f, 'h00, 0);
                wchk('h3c, 'h1f, 0);
                wchk('h3c, 'hff, 0);
                mchk(16'hbe40, 5'h00);
            end
            @(posedge clk);
            sa <= !sa;
            sb <= !sb;
            repeat (4) @(posedge clk);
            bus(0, 'h3f, 0);
            chk("config", q, mr['h3f]);
            chk("flags", flg, mr['h3c] >> 5);
            chk("vector", vec, j < 2 ? 'hfffa : 'hbffa);
            chk("watchdog", ctl.watchdog_enable, !mr['h3f][2]);
            chk("pullup", ctl.pullup_register_enable, mr['h3f][4]);
            chk("priority", ctl.priority_select, mr['h3c] & 'h1f);
            bus(0, 'h38, 0);
            chk("options two", q, mr['h38]);
            chk("read vis", ctl.internal_read_visibility_control, mr['h38][4]);
            repeat (8) begin
                @(posedge clk);
                ifc <= 1'(xs());
                @(negedge clk);
                chk("fetch", {a_oe, a_o}, {ifc, 1'b0});
                chk("pin a", pa, !ifc & sa);
            end
        end
        end_sim();
    end
endmodule
`default_nettype wire
